//--- pkg/vram_ctrl_pkg.sv
// constants, types and timing for the video memory port controller
// assumes a 200 MHz core clock and a single-slave AHB-Lite register bus
// What this block does
// (R1) Device latches row then column address bits
// (R2) Address stable before each strobe falls
// (R3) Transfer: row picks row, column sets tap
// (R4) Row strobe fall starts every cycle
// (R5) Column strobe fall latches column and tap
// (R6) Transfer gate low before row strobe falls
// (R7) Low write strobe at row fall masks
// (R8) Write strobe level picks transfer direction
// (R9) Special select picks extra functions
// (R10) Early write: write strobe before column strobe
// (R11) Random outputs drive only while both low
// (R12) Random pins float during transfer cycles
// (R13) Write mask taken at row strobe fall
// (R14) Last transfer sets serial pin direction
// (R15) Serial pointer wraps modulo 512 upward
// (R16) Serial data moves on shift clock rise
// (R17) Shift port enable gates serial pins
// (R18) Pseudo transfer only switches to input
// (R19) Active half flag follows pointer half; the model moves it on a shift only in split mode
// (R20) Flag updates when plain transfer completes
// (R21) Power-up pause, refreshes, transfer, shifts
// (R22) Split read transfer loads one half
// (R23) Split mode continues in opposite half
// (R24) Column-first cycle refreshes internal row
// (R25) Serial pointer is a loaded counter
package vram_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ROW    = 8'h04;
	localparam logic [7:0] OFS_COL    = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// field positions
	localparam int CMD_DSF_BIT   = 4;
	localparam int WD_MASK_LSB   = 4;
	localparam int ST_RDATA_LSB  = 8;
	localparam int ST_SIN_LSB    = 12;
	// values after reset
	localparam logic [8:0] ADDR_RST = 9'h000;
	localparam logic [3:0] NIB_RST  = 4'h0;
	// timing: strobe phase and power-up pause
	localparam int CLK_PS    = 5000;
	localparam int PHASE_NS  = 40;
	localparam int PAUSE_US  = 200;
	localparam logic [7:0] PHASE_CYC = 8'((PHASE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam int PAUSE_CYC = (PAUSE_US * 1000000) / CLK_PS;
	// power-up sequence lengths
	localparam int INIT_CBR   = 8;
	localparam int INIT_SHIFT = 2;
	localparam logic [3:0] INIT_OPS = 4'(INIT_CBR + 1 + INIT_SHIFT);
	// commands written to the command register
	typedef enum logic [3:0] {
		OP_CBR    = 4'h0,
		OP_READ   = 4'h1,
		OP_WRITE  = 4'h2,
		OP_MWRITE = 4'h3,
		OP_RXFER  = 4'h4,
		OP_SPLIT  = 4'h5,
		OP_WXFER  = 4'h6,
		OP_PSEUDO = 4'h7,
		OP_LMASK  = 4'h8,
		OP_LCOLOR = 4'h9,
		OP_SHIFT  = 4'hA
	} op_t;
	// sequencer states, gray along setup-ras-col-cas-end
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_SETUP = 3'h1,
		S_RAS   = 3'h3,
		S_COL   = 3'h2,
		S_CAS   = 3'h6,
		S_END   = 3'h7,
		S_SHL   = 3'h5,
		S_SHH   = 3'h4
	} st_t;
endpackage

//--- src/pin_sync.sv
// two-flop synchroniser for the device's returning pins
// assumes inputs are asynchronous to core_clk_in
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 9
) (
	input  wire logic         core_clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_t;

	sync_t r_reg;
	sync_t r_next;

	// first stage feeds only the second stage
	always_comb begin
		r_next = r_reg;
		r_next.first = async_in;
		r_next.second = r_reg.first;
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sync_out = r_reg.second;
endmodule

//--- src/vram_port_ctrl.sv
// host controller that drives a dual-ported video memory through its pins
// assumes one AHB-Lite master, device pins asynchronous to core_clk_in
`timescale 1ns/1ps
module vram_port_ctrl #(
	parameter logic [15:0] PAUSE_CYCLES = 16'(vram_ctrl_pkg::PAUSE_CYC)
) (
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic             row_strobe_n_out,
	output logic             column_strobe_n_out,
	output logic             transfer_gate_n_out,
	output logic             write_strobe_n_out,
	output logic             special_function_select_out,
	output logic             shift_port_enable_n_out,
	output logic             shift_clock_out,
	output logic [8:0]       multiplexed_address_out,
	input  wire logic [3:0]  random_data_pins_in,
	output logic      [3:0]  random_data_pins_out,
	output logic             random_data_pins_oe_out,
	input  wire logic [3:0]  serial_data_pins_in,
	output logic      [3:0]  serial_data_pins_out,
	output logic             serial_data_pins_oe_out,
	input  wire logic        active_half_flag_in
);
	typedef struct packed {
		vram_ctrl_pkg::st_t st;
		vram_ctrl_pkg::op_t op;
		logic [7:0]  ph;
		logic [15:0] pause;
		logic [3:0]  init_ops;
		logic        init_done;
		logic        refused;
		logic        in_mode;
		logic [8:0]  row;
		logic [8:0]  col;
		logic [3:0]  wdata;
		logic [3:0]  wmask;
		logic        cas_dsf;
		logic [3:0]  rdata;
		logic [3:0]  sin;
		logic        ras_n;
		logic        cas_n;
		logic        trg_n;
		logic        w_n;
		logic        special_function_select;
		logic        se_n;
		logic        sclk;
		logic [8:0]  addr;
		logic [3:0]  dq;
		logic        dq_oe;
		logic [3:0]  sdq;
		logic        sdq_oe;
		logic        ap_wr;
		logic [7:0]  ap_addr;
		logic [31:0] hrdata;
	} state_t;

	state_t r_reg;
	state_t r_next;
	logic [8:0] pins_sync;

	// device data and flag pins cross into the core domain here
	pin_sync #(
		.W(9)
	) u_sync (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.async_in    ({active_half_flag_in, serial_data_pins_in, random_data_pins_in}),
		.sync_out    (pins_sync)
	);

	function automatic logic is_xfer(input vram_ctrl_pkg::op_t op);
		is_xfer = (op == vram_ctrl_pkg::OP_RXFER) || (op == vram_ctrl_pkg::OP_SPLIT)
			|| (op == vram_ctrl_pkg::OP_WXFER) || (op == vram_ctrl_pkg::OP_PSEUDO);
	endfunction

	function automatic logic is_write(input vram_ctrl_pkg::op_t op);
		is_write = (op == vram_ctrl_pkg::OP_WRITE) || (op == vram_ctrl_pkg::OP_MWRITE)
			|| (op == vram_ctrl_pkg::OP_LMASK) || (op == vram_ctrl_pkg::OP_LCOLOR);
	endfunction

	// bus slave, power-up sequencer and strobe sequencer in one next-state block
	always_comb begin
		logic                go;
		vram_ctrl_pkg::op_t  go_op;
		logic                last;
		logic [31:0]         rd;
		r_next = r_reg;
		go = 1'b0;
		go_op = vram_ctrl_pkg::OP_CBR;
		last = (r_reg.ph == vram_ctrl_pkg::PHASE_CYC - 8'h01);
		rd = 32'h0000_0000;
		// register writes land in the data phase
		if (r_reg.ap_wr) begin
			case (r_reg.ap_addr)
				vram_ctrl_pkg::OFS_CMD: begin
					// busy or still powering up: the command is dropped and flagged
					if (r_reg.st == vram_ctrl_pkg::S_IDLE && r_reg.init_done) begin
						go = 1'b1;
						go_op = vram_ctrl_pkg::op_t'(hwdata_in[3:0]);
						r_next.cas_dsf = hwdata_in[vram_ctrl_pkg::CMD_DSF_BIT];
						r_next.refused = 1'b0;
					end else begin
						r_next.refused = 1'b1;
					end
				end
				vram_ctrl_pkg::OFS_ROW: r_next.row = hwdata_in[8:0];
				vram_ctrl_pkg::OFS_COL: r_next.col = hwdata_in[8:0];
				vram_ctrl_pkg::OFS_WDATA: begin
					r_next.wdata = hwdata_in[3:0];
					r_next.wmask = hwdata_in[vram_ctrl_pkg::WD_MASK_LSB +: 4];
				end
				default: r_next.refused = r_reg.refused;
			endcase
		end
		// read data is registered at the address phase, zero for unmapped offsets
		case (haddr_in[7:0])
			vram_ctrl_pkg::OFS_CMD: rd = 32'({r_reg.cas_dsf, r_reg.op});
			vram_ctrl_pkg::OFS_ROW: rd = 32'(r_reg.row);
			vram_ctrl_pkg::OFS_COL: rd = 32'(r_reg.col);
			vram_ctrl_pkg::OFS_WDATA: rd = 32'({r_reg.wmask, r_reg.wdata});
			vram_ctrl_pkg::OFS_STATUS: begin
				rd[0] = (r_reg.st != vram_ctrl_pkg::S_IDLE);
				rd[1] = r_reg.init_done;
				rd[2] = r_reg.refused;
				rd[3] = r_reg.in_mode;
				rd[4] = pins_sync[8];
				rd[vram_ctrl_pkg::ST_RDATA_LSB +: 4] = r_reg.rdata;
				rd[vram_ctrl_pkg::ST_SIN_LSB +: 4] = r_reg.sin;
			end
			default: rd = 32'h0000_0000;
		endcase
		r_next.ap_wr = 1'b0;
		if (hsel_in && htrans_in[1] && hready_in) begin
			r_next.ap_wr = hwrite_in;
			r_next.ap_addr = haddr_in[7:0];
			if (!hwrite_in) begin
				r_next.hrdata = rd;
			end
		end
		// power-up: pause, eight refreshes, one read transfer, two shift clocks
		if (!r_reg.init_done && r_reg.st == vram_ctrl_pkg::S_IDLE) begin
			if (r_reg.pause != 16'h0000) begin
				r_next.pause = r_reg.pause - 16'h0001;                    // [R21]
			end else if (r_reg.init_ops < vram_ctrl_pkg::INIT_OPS) begin
				go = 1'b1;
				r_next.init_ops = r_reg.init_ops + 4'h1;
				if (r_reg.init_ops < 4'(vram_ctrl_pkg::INIT_CBR)) begin
					go_op = vram_ctrl_pkg::OP_CBR;                        // [R21]
				end else if (r_reg.init_ops == 4'(vram_ctrl_pkg::INIT_CBR)) begin
					go_op = vram_ctrl_pkg::OP_RXFER;                      // [R21]
				end else begin
					go_op = vram_ctrl_pkg::OP_SHIFT;                      // [R21]
				end
			end else begin
				r_next.init_done = 1'b1;
			end
		end
		// strobe sequencer: each state holds its pins for one phase
		if (r_reg.st != vram_ctrl_pkg::S_IDLE) begin
			r_next.ph = last ? 8'h00 : r_reg.ph + 8'h01;
		end
		case (r_reg.st)
			vram_ctrl_pkg::S_IDLE: begin
				if (go && go_op == vram_ctrl_pkg::OP_SHIFT) begin
					// host writes serial data only while the device is in input mode
					r_next.st = vram_ctrl_pkg::S_SHL;
					r_next.op = go_op;
					r_next.sdq = r_reg.wdata;
					r_next.sdq_oe = r_reg.in_mode;
				end else if (go) begin
					// levels sampled by the device at the row strobe fall
					r_next.st = vram_ctrl_pkg::S_SETUP;
					r_next.op = go_op;
					r_next.addr = r_reg.row;                                 // [R2] [R3]
					r_next.cas_n = (go_op != vram_ctrl_pkg::OP_CBR);
					r_next.trg_n = !is_xfer(go_op);                          // [R6]
					r_next.w_n = !(go_op == vram_ctrl_pkg::OP_MWRITE
						|| go_op == vram_ctrl_pkg::OP_WXFER
						|| go_op == vram_ctrl_pkg::OP_PSEUDO);
					r_next.special_function_select = (go_op == vram_ctrl_pkg::OP_SPLIT)
						|| (go_op == vram_ctrl_pkg::OP_LMASK)
						|| (go_op == vram_ctrl_pkg::OP_LCOLOR);
					// serial enable high at the row fall only where a pseudo transfer is meant
					r_next.se_n = (go_op == vram_ctrl_pkg::OP_PSEUDO);
					r_next.dq = r_reg.wmask;
					r_next.dq_oe = (go_op == vram_ctrl_pkg::OP_MWRITE);
				end
			end
			vram_ctrl_pkg::S_SETUP: begin
				if (last) begin
					r_next.st = vram_ctrl_pkg::S_RAS;
					r_next.ras_n = 1'b0;
				end
			end
			vram_ctrl_pkg::S_RAS: begin
				if (last && r_reg.op == vram_ctrl_pkg::OP_CBR) begin
					r_next.st = vram_ctrl_pkg::S_END;
					r_next.ras_n = 1'b1;
					r_next.cas_n = 1'b1;
				end else if (last) begin
					// column address or tap point goes out a full phase early
					r_next.st = vram_ctrl_pkg::S_COL;
					r_next.addr = r_reg.col;                                 // [R2] [R3]
					r_next.dq_oe = 1'b0;
					r_next.special_function_select = (r_reg.op == vram_ctrl_pkg::OP_LCOLOR)
						|| (!is_xfer(r_reg.op) && r_reg.op != vram_ctrl_pkg::OP_LMASK
						&& r_reg.cas_dsf);
					if (is_write(r_reg.op)) begin
						r_next.w_n = 1'b0;                                   // [R10]
						r_next.dq = r_reg.wdata;
						r_next.dq_oe = 1'b1;
					end else if (r_reg.op == vram_ctrl_pkg::OP_READ) begin
						r_next.trg_n = 1'b0;
					end
				end
			end
			vram_ctrl_pkg::S_COL: begin
				if (last) begin
					r_next.st = vram_ctrl_pkg::S_CAS;
					r_next.cas_n = 1'b0;
				end
			end
			vram_ctrl_pkg::S_CAS: begin
				if (last) begin
					// read data has had a full phase less the sync delay to settle
					if (r_reg.op == vram_ctrl_pkg::OP_READ) begin
						r_next.rdata = pins_sync[3:0];
					end
					if (r_reg.op == vram_ctrl_pkg::OP_RXFER || r_reg.op == vram_ctrl_pkg::OP_SPLIT) begin
						r_next.in_mode = 1'b0;
					end else if (is_xfer(r_reg.op)) begin
						r_next.in_mode = 1'b1;
					end
					r_next.st = vram_ctrl_pkg::S_END;
					r_next.ras_n = 1'b1;
					r_next.cas_n = 1'b1;
					r_next.trg_n = 1'b1;
					r_next.w_n = 1'b1;
					r_next.special_function_select = 1'b0;
					r_next.se_n = 1'b0;
					r_next.dq_oe = 1'b0;
				end
			end
			vram_ctrl_pkg::S_END: begin
				// precharge time before the next cycle may start
				if (last) begin
					r_next.st = vram_ctrl_pkg::S_IDLE;
				end
			end
			vram_ctrl_pkg::S_SHL: begin
				if (last) begin
					r_next.st = vram_ctrl_pkg::S_SHH;
					r_next.sclk = 1'b1;
				end
			end
			vram_ctrl_pkg::S_SHH: begin
				if (last) begin
					r_next.st = vram_ctrl_pkg::S_IDLE;
					r_next.sclk = 1'b0;
					r_next.sdq_oe = 1'b0;
					r_next.sin = pins_sync[7:4];
				end
			end
			default: r_next.st = vram_ctrl_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r_reg <= '0;
			r_reg.st <= vram_ctrl_pkg::S_IDLE;
			r_reg.op <= vram_ctrl_pkg::OP_CBR;
			r_reg.pause <= PAUSE_CYCLES;
			r_reg.row <= vram_ctrl_pkg::ADDR_RST;
			r_reg.col <= vram_ctrl_pkg::ADDR_RST;
			r_reg.wdata <= vram_ctrl_pkg::NIB_RST;
			r_reg.wmask <= vram_ctrl_pkg::NIB_RST;
			r_reg.ras_n <= 1'b1;
			r_reg.cas_n <= 1'b1;
			r_reg.trg_n <= 1'b1;
			r_reg.w_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// all pins come straight from flip-flops to avoid glitches on strobes
	assign hrdata_out = r_reg.hrdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign row_strobe_n_out = r_reg.ras_n;
	assign column_strobe_n_out = r_reg.cas_n;
	assign transfer_gate_n_out = r_reg.trg_n;
	assign write_strobe_n_out = r_reg.w_n;
	assign special_function_select_out = r_reg.special_function_select;
	assign shift_port_enable_n_out = r_reg.se_n;
	assign shift_clock_out = r_reg.sclk;
	assign multiplexed_address_out = r_reg.addr;
	assign random_data_pins_out = r_reg.dq;
	assign random_data_pins_oe_out = r_reg.dq_oe;
	assign serial_data_pins_out = r_reg.sdq;
	assign serial_data_pins_oe_out = r_reg.sdq_oe;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	addr_before_ras_a: assert property ($fell(r_reg.ras_n) |-> $stable(r_reg.addr)) // [R2]
		else $error("address moved as row strobe fell");
	addr_before_cas_a: assert property ($fell(r_reg.cas_n) && r_reg.op != vram_ctrl_pkg::OP_CBR
		|-> $stable(r_reg.addr) && r_reg.addr == r_reg.col) // [R2]
		else $error("column address not steady at column strobe fall");
	tap_row_select_a: assert property ($fell(r_reg.ras_n) && is_xfer(r_reg.op)
		|-> r_reg.addr == r_reg.row) // [R3]
		else $error("transfer row address wrong");
	gate_before_ras_a: assert property ($fell(r_reg.ras_n) && is_xfer(r_reg.op)
		|-> !r_reg.trg_n && $past(!r_reg.trg_n, 2)) // [R6]
		else $error("transfer gate not low before row strobe");
	array_gate_high_a: assert property ($fell(r_reg.ras_n) && !is_xfer(r_reg.op)
		|-> r_reg.trg_n) // [R6]
		else $error("transfer gate low in array cycle");
	early_write_a: assert property ($fell(r_reg.cas_n) && is_write(r_reg.op)
		|-> !r_reg.w_n && $past(!r_reg.w_n) && r_reg.dq_oe) // [R10]
		else $error("write strobe not ahead of column strobe");
	pause_first_a: assert property ($fell(r_reg.ras_n) |-> r_reg.pause == 16'h0000) // [R21]
		else $error("row strobe before power-up pause ended");
	init_complete_a: assert property ($rose(r_reg.init_done)
		|-> r_reg.init_ops == vram_ctrl_pkg::INIT_OPS && !r_reg.in_mode) // [R21]
		else $error("init finished without full sequence");
endmodule

//--- test/vram_dev_model.sv
// behavioural model of the dual-ported video memory on the controller's pins
// assumes strobes arrive as plain levels; no clock, no reset pin
`timescale 1ns/1ps
module vram_dev_model (
	input  wire logic       row_strobe_n_in,
	input  wire logic       column_strobe_n_in,
	input  wire logic       transfer_gate_n_in,
	input  wire logic       write_strobe_n_in,
	input  wire logic       special_function_select_in,
	input  wire logic       shift_port_enable_n_in,
	input  wire logic       shift_clock_in,
	input  wire logic [8:0] multiplexed_address_in,
	input  wire logic [3:0] random_data_pins_in,
	output logic      [3:0] random_data_pins_out,
	output logic            random_data_drive_out,
	input  wire logic [3:0] serial_data_pins_in,
	output logic      [3:0] serial_data_pins_out,
	output logic            serial_data_drive_out,
	output logic            active_half_flag_out
);
	logic [3:0] cells [0:262143];
	logic [3:0] shift_buf [0:511];
	logic [8:0] row_reg, col_reg, ptr_reg;
	logic       is_xfer = 1'b0, wpb_on, wr_at_row, fn_at_row, fn_at_col, pseudo_at_row;
	logic       split_mode = 1'b0, input_mode = 1'b0;
	logic [3:0] mask_reg, rd_last = 4'h0, sd_last = 4'h0;
	int         refresh_count = 0, read_xfer_count = 0, shift_count = 0;
	realtime    first_strobe_t = 0;

	// write a nibble, through the mask when write-per-bit is on
	task automatic store(input logic [3:0] d);
		if (!wr_at_row && fn_at_row) begin
			if (!fn_at_col) mask_reg = d;
		end else if (wpb_on) begin
			cells[{row_reg, col_reg}] = (cells[{row_reg, col_reg}] & ~mask_reg) | (d & mask_reg);
		end else begin
			cells[{row_reg, col_reg}] = d;
		end
	endtask

	// the row strobe fall opens every cycle and captures the control levels
	always @(negedge row_strobe_n_in) begin
		if (first_strobe_t == 0) first_strobe_t = $realtime;
		row_reg = multiplexed_address_in;
		is_xfer = !transfer_gate_n_in && column_strobe_n_in;
		wr_at_row = !write_strobe_n_in;
		fn_at_row = special_function_select_in;
		pseudo_at_row = is_xfer && wr_at_row && shift_port_enable_n_in && !fn_at_row;
		if (!column_strobe_n_in) refresh_count++;
		wpb_on = !is_xfer && wr_at_row;
		if (wpb_on && !fn_at_row) mask_reg = random_data_pins_in;
	end

	// column fall takes column or tap; early write data is taken here
	always @(negedge column_strobe_n_in) begin
		if (first_strobe_t == 0) first_strobe_t = $realtime;
		if (!row_strobe_n_in) begin
			col_reg = multiplexed_address_in;
			fn_at_col = special_function_select_in;
			if (!is_xfer && !write_strobe_n_in) store(random_data_pins_in);
		end
	end

	// delayed write: data strobed by the write strobe after the column strobe
	always @(negedge write_strobe_n_in) begin
		if (!row_strobe_n_in && !column_strobe_n_in && !is_xfer) store(random_data_pins_in);
	end

	// transfers complete at the row strobe rise; pointer and flag take the tap
	always @(posedge row_strobe_n_in) begin
		if (is_xfer) begin
			split_mode = !wr_at_row && fn_at_row;
			if (pseudo_at_row) begin
				input_mode = 1'b1;
			end else if (wr_at_row) begin
				for (int i = 0; i < 512; i++) cells[{row_reg, 9'(i)}] = shift_buf[i];
				input_mode = 1'b1;
			end else begin
				// a split load fills only the half not being shifted
				for (int i = 0; i < 512; i++)
					if (!split_mode || ((i >= 256) != active_half_flag_out))
						shift_buf[i] = cells[{row_reg, 9'(i)}];
				input_mode = 1'b0;
				read_xfer_count++;
			end
			ptr_reg = col_reg;
			active_half_flag_out = col_reg[8];
		end
		is_xfer = 1'b0;
	end

	// outputs drive only while column strobe and gate are low, never in a transfer
	assign random_data_drive_out = !column_strobe_n_in && !transfer_gate_n_in &&
		!row_strobe_n_in && !is_xfer && write_strobe_n_in;
	always @(*) if (random_data_drive_out) rd_last = cells[{row_reg, col_reg}];
	// no pull-ups: a released line shows the inverse so a stale value never matches
	assign random_data_pins_out = random_data_drive_out ? rd_last : ~rd_last;

	// each shift-clock rise moves one nibble; the enable gates both modes
	always @(posedge shift_clock_in) begin
		shift_count++;
		if (!shift_port_enable_n_in) begin
			if (input_mode) shift_buf[ptr_reg] = serial_data_pins_in;
			else sd_last = shift_buf[ptr_reg];
			ptr_reg = ptr_reg + 9'h001;
			if (split_mode && ptr_reg[7:0] == 8'h00) active_half_flag_out = ptr_reg[8];
		end
	end
	assign serial_data_drive_out = !input_mode && !shift_port_enable_n_in;
	assign serial_data_pins_out = serial_data_drive_out ? sd_last : ~sd_last;
endmodule

//--- test/vram_port_ctrl_tb.sv
// self-checking bench for the video memory port controller
// assumes vram_dev_model on the pins and the bench as sole bus master
`timescale 1ns/1ps
module vram_port_ctrl_tb;
	localparam int PAUSE = 20;
	logic        core_clk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        row_n, col_n, gate_n, wr_n, fsel, shen_n, shclk, half;
	logic        rdo_oe, sdo_oe, m_rdrv, m_sdrv;
	logic [8:0]  maddr;
	logic [3:0]  rdo, sdo, m_rd, m_sd, rd_wire, sd_wire;
	int          errors, check_count, base;
	realtime     release_t;

	// the wire shows whoever drives it; the model inverts its idle value itself
	assign rd_wire = rdo_oe ? rdo : m_rd;
	assign sd_wire = sdo_oe ? sdo : m_sd;

	vram_port_ctrl #(.PAUSE_CYCLES(16'(PAUSE))) dut (
		.core_clk_in(core_clk), .reset_n_in(reset_n), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
		.hresp_out(hresp), .row_strobe_n_out(row_n), .column_strobe_n_out(col_n),
		.transfer_gate_n_out(gate_n), .write_strobe_n_out(wr_n),
		.special_function_select_out(fsel), .shift_port_enable_n_out(shen_n),
		.shift_clock_out(shclk), .multiplexed_address_out(maddr),
		.random_data_pins_in(rd_wire), .random_data_pins_out(rdo),
		.random_data_pins_oe_out(rdo_oe), .serial_data_pins_in(sd_wire),
		.serial_data_pins_out(sdo), .serial_data_pins_oe_out(sdo_oe),
		.active_half_flag_in(half));

	vram_dev_model partner (
		.row_strobe_n_in(row_n), .column_strobe_n_in(col_n), .transfer_gate_n_in(gate_n),
		.write_strobe_n_in(wr_n), .special_function_select_in(fsel),
		.shift_port_enable_n_in(shen_n), .shift_clock_in(shclk),
		.multiplexed_address_in(maddr), .random_data_pins_in(rd_wire),
		.random_data_pins_out(m_rd), .random_data_drive_out(m_rdrv),
		.serial_data_pins_in(sd_wire), .serial_data_pins_out(m_sd),
		.serial_data_drive_out(m_sdrv), .active_half_flag_out(half));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single word: address phase held until hready, then the data phase
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, ofs};
		hwrite <= wr;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	// status is polled under a bounded count until the chosen bit settles
	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		do begin
			bus(1'b0, vram_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
			k++;
		end while (rd[b] !== v && k < 400);
		if (k >= 400) chk(32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic prep(input logic [8:0] r, input logic [8:0] c, input logic [31:0] w);
		bus(1'b1, vram_ctrl_pkg::OFS_ROW, {23'h00_0000, r});
		bus(1'b1, vram_ctrl_pkg::OFS_COL, {23'h00_0000, c});
		bus(1'b1, vram_ctrl_pkg::OFS_WDATA, w);
	endtask

	task automatic run(input logic [3:0] op);
		bus(1'b1, vram_ctrl_pkg::OFS_CMD, {28'h000_0000, op});
		poll(0, 1'b0);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// two parties must never drive one data line together
	always @(posedge core_clk) begin
		if ((rdo_oe === 1'b1 && m_rdrv === 1'b1) || (sdo_oe === 1'b1 && m_sdrv === 1'b1))
			chk(32'h0000_0001, 32'h0000_0000);
	end

	initial begin
		#200_000;
		errors++;
		tally_and_finish();
	end

	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		errors = 0;
		check_count = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		release_t = $realtime;
		// a command during start-up is dropped and flagged
		bus(1'b1, vram_ctrl_pkg::OFS_CMD, 32'h0000_0001);
		bus(1'b0, vram_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
		chk({30'h0, rd[2:1]}, 32'h0000_0002);
		poll(1, 1'b1);
		chk({31'h0, (partner.first_strobe_t - release_t) >= PAUSE * 5.0}, 32'h1);
		chk({31'h0, partner.refresh_count >= 8}, 32'h0000_0001);
		chk(32'(partner.read_xfer_count), 32'h0000_0001);
		chk(32'(partner.shift_count), 32'h0000_0002);
		// plain write, then read back through the random port
		prep(9'h1A5, 9'h0F3, 32'h0000_0009);
		run(vram_ctrl_pkg::OP_WRITE);
		chk({28'h0, partner.cells[{9'h1A5, 9'h0F3}]}, 32'h0000_0009);
		run(vram_ctrl_pkg::OP_READ);
		chk({20'h0_0000, rd[11:8], 5'h0, rd[2:0]}, 32'h0000_0902);
		// masked write keeps bits whose mask is low: 1001 merged with 0110 by 0101
		prep(9'h1A5, 9'h0F3, 32'h0000_0056);
		run(vram_ctrl_pkg::OP_MWRITE);
		run(vram_ctrl_pkg::OP_READ);
		chk({28'h0, rd[11:8]}, 32'h0000_000C);
		// read transfer at the last tap, then the pointer wraps
		prep(9'h1A5, 9'h1FF, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_RXFER);
		chk({30'h0, rd[4:3]}, 32'h0000_0002);
		run(vram_ctrl_pkg::OP_SHIFT);
		run(vram_ctrl_pkg::OP_SHIFT);
		chk({23'h0, partner.ptr_reg}, 32'h0000_0001);
		// split load just below the half boundary; one shift crosses it
		prep(9'h1A5, 9'h0FF, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_SPLIT);
		chk({31'h0, rd[4]}, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_SHIFT);
		chk({31'h0, rd[4]}, 32'h0000_0001);
		// reload the buffer, then write it into another row
		prep(9'h1A5, 9'h0F3, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_RXFER);
		run(vram_ctrl_pkg::OP_SHIFT);
		chk({28'h0, rd[15:12]}, 32'h0000_000C);
		prep(9'h002, 9'h000, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_WXFER);
		chk({28'h0, partner.cells[{9'h002, 9'h0F3}]}, 32'h0000_000C);
		chk({31'h0, rd[3]}, 32'h0000_0001);
		// pseudo transfer moves nothing into the untouched row
		prep(9'h003, 9'h010, 32'h0000_0005);
		run(vram_ctrl_pkg::OP_PSEUDO);
		chk({28'h0, partner.cells[{9'h003, 9'h0F3}]}, {28'h0, 4'hx});
		chk({31'h0, rd[3]}, 32'h0000_0001);
		run(vram_ctrl_pkg::OP_SHIFT);
		chk({28'h0, partner.shift_buf[9'h010]}, 32'h0000_0005);
		// column-first refresh; a second command while it runs is refused
		base = partner.refresh_count;
		bus(1'b1, vram_ctrl_pkg::OFS_CMD, 32'h0000_0000);
		run(vram_ctrl_pkg::OP_CBR);
		chk(32'(partner.refresh_count - base), 32'h0000_0001);
		chk({31'h0, rd[2]}, 32'h0000_0001);
		// an unmapped offset reads as zero
		bus(1'b0, 8'h20, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
